// [dual_clock_flagged_fifo.sv]
// Deep 18-bit buffer with write and read clocks taken as sampled pins.
// Assumes CLK runs several times faster than either link clock and that
// data and controls are stable around each link clock rising edge.
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - Depth 32768 or 65536, 18-bit words
// - Enabled write clock edge stores input word
// - Enabled read clock edge presents next word
// - Write and read clocks fully independent
// - Standard timing: word appears only after read
// - Fall-through: first word after three transitions
// - Fall-through: later words need read enable
// - Timing mode latched during master reset
// - Fall-through outputs chain into next inputs
// - Status pins: empty/full or ready per mode
// - Half, almost-empty, almost-full in both modes
// - Independent thresholds, defaults 127 or 1023
// - Load select picks default and load method
// - Serial load: one bit per enabled edge
// - Parallel load: offsets from data inputs
// - Offsets readable onto outputs in either method
// - Master reset zeroes both pointers
// - After master reset flags show new settings
// - Partial reset zeroes pointers, keeps settings
// - Retransmit rewinds only the read pointer
// - Output enable drives DATA_OUT_BUS_OE; data outputs stay driven
// - Almost-empty low when count below offset
// - Almost-full low when count above limit
// - Both resets clear output register
// - Retransmit briefly masks empty or ready
module dual_clock_flagged_fifo #(
  parameter int DEPTH = fifo_pkg::DEPTH_SMALL
) (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic WRITE_CLOCK,
  input wire logic READ_CLOCK,
  input wire logic WRITE_ENABLE_N,
  input wire logic READ_ENABLE_N,
  input wire logic [fifo_pkg::WORD_W-1:0] DATA_IN_BUS,
  input wire logic OFFSET_LOAD_SELECT_N,
  input wire logic SERIAL_LOAD_ENABLE_N,
  input wire logic MODE_SELECT_SERIAL_IN,
  input wire logic MASTER_RESET_N,
  input wire logic PARTIAL_RESET_N,
  input wire logic RETRANSMIT_N,
  input wire logic OUTPUT_ENABLE_N,
  output logic [fifo_pkg::WORD_W-1:0] DATA_OUT_BUS,
  output logic DATA_OUT_BUS_OE,
  output logic EMPTY_OR_OUT_READY,
  output logic FULL_OR_IN_READY,
  output logic HALF_FULL_N,
  output logic ALMOST_EMPTY_N,
  output logic ALMOST_FULL_N
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [fifo_pkg::PTR_W-1:0] CAPACITY = fifo_pkg::PTR_W'(DEPTH);
  localparam logic [fifo_pkg::PTR_W-1:0] HALF_CAPACITY = fifo_pkg::PTR_W'(DEPTH / 2);

  fifo_pkg::state_t st;
  fifo_pkg::state_t next_st;
  fifo_pkg::pins_t pins_now;
  logic write_edge;
  logic read_edge;
  logic [fifo_pkg::PTR_W-1:0] write_count;
  logic [fifo_pkg::PTR_W-1:0] read_count;
  logic [2*fifo_pkg::OFF_W-1:0] offsets_both;
  logic hold_active;
  logic store_write;
  logic [fifo_pkg::WORD_W-1:0] store_data;

  // Depth is a build-time choice of the two supported sizes
  fifo_store #(
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_store (
    .clk(CLK),
    .wr_en(store_write),
    .wr_addr(st.wptr[AW-1:0]),
    .wr_data(st.s2.data),
    .rd_addr(st.rptr[AW-1:0]),
    .rd_data(store_data)
  );

  always_comb begin
    pins_now.write_clock = WRITE_CLOCK;
    pins_now.read_clock = READ_CLOCK;
    pins_now.write_enable_n = WRITE_ENABLE_N;
    pins_now.read_enable_n = READ_ENABLE_N;
    pins_now.offset_load_select_n = OFFSET_LOAD_SELECT_N;
    pins_now.serial_load_enable_n = SERIAL_LOAD_ENABLE_N;
    pins_now.mode_select_serial_in = MODE_SELECT_SERIAL_IN;
    pins_now.master_reset_n = MASTER_RESET_N;
    pins_now.partial_reset_n = PARTIAL_RESET_N;
    pins_now.retransmit_n = RETRANSMIT_N;
    pins_now.output_enable_n = OUTPUT_ENABLE_N;
    pins_now.data = DATA_IN_BUS;
  end

  always_comb begin
    next_st = st;
    store_write = 1'b0;
    offsets_both = {st.full_offset, st.empty_offset};
    // Every pin passes two stages; the third stage only serves edge finding
    next_st.s1 = pins_now;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    // Each link clock is edge-detected by itself, no relation assumed
    // A zeroed third stage after RST_B would fake a rise on a high clock pin
    write_edge = st.s2.write_clock & ~st.s3.write_clock & st.s3.master_reset_n;
    read_edge = st.s2.read_clock & ~st.s3.read_clock & st.s3.master_reset_n;
    // The read side sees the write pointer two cycles late, so it never
    // claims a word whose store write has not yet settled
    next_st.wptr_d1 = st.wptr;
    next_st.wptr_d2 = st.wptr_d1;
    write_count = st.wptr - st.rptr;
    read_count = st.wptr_d2 - st.rptr;
    hold_active = (st.retransmit_hold != 2'h0);

    if (!st.s2.master_reset_n) begin
      next_st.wptr = '0;
      next_st.wptr_d1 = '0;
      next_st.wptr_d2 = '0;
      next_st.rptr = '0;
      next_st.q = '0;
      next_st.out_valid = 1'b0;
      next_st.fall_count = 2'h0;
      next_st.retransmit_hold = 2'h0;
      next_st.serial_bit = fifo_pkg::SERIAL_EMPTY_LSB;
      next_st.write_offset_index = 1'b0;
      next_st.read_offset_index = 1'b0;
      next_st.fall_through_timing = st.s2.mode_select_serial_in;
      next_st.serial_mode = st.s2.offset_load_select_n;
      if (st.s2.offset_load_select_n) begin
        next_st.empty_offset = fifo_pkg::OFFSET_DEFAULT_SERIAL;
        next_st.full_offset = fifo_pkg::OFFSET_DEFAULT_SERIAL;
      end else begin
        next_st.empty_offset = fifo_pkg::OFFSET_DEFAULT_PARALLEL;
        next_st.full_offset = fifo_pkg::OFFSET_DEFAULT_PARALLEL;
      end
    end else if (!st.s2.partial_reset_n) begin
      // Mode, load method and offsets are left as they are
      next_st.wptr = '0;
      next_st.wptr_d1 = '0;
      next_st.wptr_d2 = '0;
      next_st.rptr = '0;
      next_st.q = '0;
      next_st.out_valid = 1'b0;
      next_st.fall_count = 2'h0;
      next_st.retransmit_hold = 2'h0;
      next_st.serial_bit = fifo_pkg::SERIAL_EMPTY_LSB;
      next_st.write_offset_index = 1'b0;
      next_st.read_offset_index = 1'b0;
    end else begin
      if (write_edge) begin
        if (!st.s2.offset_load_select_n) begin
          if (st.serial_mode && !st.s2.serial_load_enable_n) begin
            offsets_both[st.serial_bit] = st.s2.mode_select_serial_in;
            next_st.empty_offset = offsets_both[fifo_pkg::OFF_W-1:0];
            next_st.full_offset = offsets_both[2*fifo_pkg::OFF_W-1:fifo_pkg::OFF_W];
            next_st.serial_bit = st.serial_bit + 5'h01;
          end else if (!st.serial_mode && !st.s2.write_enable_n) begin
            if (st.write_offset_index) begin
              next_st.full_offset = st.s2.data[fifo_pkg::OFF_W-1:0];
            end else begin
              next_st.empty_offset = st.s2.data[fifo_pkg::OFF_W-1:0];
            end
            next_st.write_offset_index = ~st.write_offset_index;
          end
        end else if (!st.s2.write_enable_n && write_count != CAPACITY) begin
          store_write = 1'b1;
          next_st.wptr = st.wptr + 17'h00001;
        end
      end

      if (read_edge) begin
        if (hold_active) begin
          next_st.retransmit_hold = st.retransmit_hold - 2'h1;
        end
        if (!st.s2.retransmit_n) begin
          // Write pointer and settings stay untouched
          next_st.rptr = '0;
          next_st.retransmit_hold = fifo_pkg::RETRANSMIT_HOLD_EDGES;
          next_st.out_valid = 1'b0;
          next_st.fall_count = 2'h0;
        end else if (!st.s2.offset_load_select_n && !st.s2.read_enable_n) begin
          next_st.q = '0;
          if (st.read_offset_index) begin
            next_st.q[fifo_pkg::OFF_W-1:0] = st.full_offset;
          end else begin
            next_st.q[fifo_pkg::OFF_W-1:0] = st.empty_offset;
          end
          next_st.read_offset_index = ~st.read_offset_index;
        end else if (!hold_active) begin
          if (!st.fall_through_timing) begin
            // Nothing moves to the outputs without an enabled read
            if (!st.s2.read_enable_n && read_count != '0) begin
              next_st.q = store_data;
              next_st.rptr = st.rptr + 17'h00001;
            end
          end else if (st.out_valid) begin
            if (!st.s2.read_enable_n) begin
              if (read_count != '0) begin
                next_st.q = store_data;
                next_st.rptr = st.rptr + 17'h00001;
              end else begin
                next_st.out_valid = 1'b0;
              end
            end
          end else if (read_count != '0) begin
            // Two rising edges span the three transitions of the first word
            if (st.fall_count == fifo_pkg::FALL_THROUGH_EDGES - 2'h1) begin
              next_st.q = store_data;
              next_st.rptr = st.rptr + 17'h00001;
              next_st.out_valid = 1'b1;
              next_st.fall_count = 2'h0;
            end else begin
              next_st.fall_count = st.fall_count + 2'h1;
            end
          end
        end
      end
    end

    // Flags follow the mode and offsets currently held, so both resets
    // are reflected without any extra step
    if (st.fall_through_timing) begin
      next_st.flags.empty_or_out_ready = ~st.out_valid | hold_active;
      next_st.flags.full_or_in_ready = (write_count == CAPACITY);
    end else begin
      next_st.flags.empty_or_out_ready = ~((read_count == '0) | hold_active);
      next_st.flags.full_or_in_ready = (write_count != CAPACITY);
    end
    next_st.flags.half_full_n = ~(write_count > HALF_CAPACITY);
    next_st.flags.almost_empty_n =
      ~(read_count < {1'b0, st.empty_offset});
    next_st.flags.almost_full_n =
      ~(write_count > (CAPACITY - {1'b0, st.full_offset}));
    next_st.flags.data_out_enable = ~st.s2.output_enable_n;
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      st <= fifo_pkg::STATE_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Data outputs feed the next unit's inputs directly when chained
  assign DATA_OUT_BUS = st.q;
  assign DATA_OUT_BUS_OE = st.flags.data_out_enable;
  assign EMPTY_OR_OUT_READY = st.flags.empty_or_out_ready;
  assign FULL_OR_IN_READY = st.flags.full_or_in_ready;
  assign HALF_FULL_N = st.flags.half_full_n;
  assign ALMOST_EMPTY_N = st.flags.almost_empty_n;
  assign ALMOST_FULL_N = st.flags.almost_full_n;

endmodule
`default_nettype wire

// [dual_fifo_monitor.sv]
// Checker of the buffer's pin behaviour, bound to the top module.
// Assumes one CLK domain samples both link clocks.
`timescale 1ns/10ps
`default_nettype none
module dual_fifo_monitor (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic WRITE_CLOCK,
  input wire logic READ_CLOCK,
  input wire logic MODE_SELECT_SERIAL_IN,
  input wire logic MASTER_RESET_N,
  input wire logic PARTIAL_RESET_N,
  input wire logic OUTPUT_ENABLE_N,
  input wire logic [fifo_pkg::WORD_W-1:0] DATA_OUT_BUS,
  input wire logic DATA_OUT_BUS_OE,
  input wire logic EMPTY_OR_OUT_READY,
  input wire logic FULL_OR_IN_READY,
  input wire logic HALF_FULL_N,
  input wire logic ALMOST_EMPTY_N,
  input wire logic ALMOST_FULL_N
);
  logic [3:0] ev;
  logic [3:0] quiet;
  logic [4:0] fl;
  assign fl = {EMPTY_OR_OUT_READY, FULL_OR_IN_READY, HALF_FULL_N, ALMOST_EMPTY_N, ALMOST_FULL_N};
  // Data and flag outputs may only move in the few cycles after a link rise or a reset change
  always_ff @(posedge CLK) begin
    ev <= {WRITE_CLOCK, READ_CLOCK, MASTER_RESET_N, PARTIAL_RESET_N};
    if (!RST_B || (WRITE_CLOCK && !ev[3]) || (READ_CLOCK && !ev[2]) ||
        ev[1:0] != {MASTER_RESET_N, PARTIAL_RESET_N})
      quiet <= 4'h0;
    else if (quiet != 4'hF)
      quiet <= quiet + 4'h1;
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  chk_oe_off: assert property (OUTPUT_ENABLE_N [*6] |-> !DATA_OUT_BUS_OE)
    else $error("outputs driven while disabled");
  chk_oe_on: assert property (!OUTPUT_ENABLE_N [*6] |-> DATA_OUT_BUS_OE)
    else $error("outputs not driven while enabled");
  chk_mreset_data: assert property (
    !MASTER_RESET_N [*6] |-> DATA_OUT_BUS == 18'h00000)
    else $error("output word kept in master reset");
  chk_mreset_levels: assert property (
    !MASTER_RESET_N [*8] |-> !ALMOST_EMPTY_N && ALMOST_FULL_N && HALF_FULL_N)
    else $error("levels wrong in master reset");
  chk_mode_flags: assert property (
    !MASTER_RESET_N [*8] |-> EMPTY_OR_OUT_READY == MODE_SELECT_SERIAL_IN &&
      FULL_OR_IN_READY != MODE_SELECT_SERIAL_IN)
    else $error("status pins ignore selected mode");
  chk_preset_clear: assert property (
    !PARTIAL_RESET_N [*8] |-> DATA_OUT_BUS == 18'h00000 && !ALMOST_EMPTY_N)
    else $error("partial reset left data");
  chk_data_quiet: assert property (quiet >= 4'h8 |-> $stable(DATA_OUT_BUS))
    else $error("output word moved without a read");
  chk_flags_quiet: assert property (quiet >= 4'h8 |-> $stable(fl))
    else $error("flags moved without an edge");
  cover property (!MASTER_RESET_N && MODE_SELECT_SERIAL_IN);
  cover property ($fell(DATA_OUT_BUS_OE));
  cover property ($fell(EMPTY_OR_OUT_READY));
  cover property ($fell(ALMOST_FULL_N));
endmodule
bind dual_clock_flagged_fifo dual_fifo_monitor u_mon (.CLK, .RST_B, .WRITE_CLOCK, .READ_CLOCK,
  .MODE_SELECT_SERIAL_IN, .MASTER_RESET_N, .PARTIAL_RESET_N, .OUTPUT_ENABLE_N, .DATA_OUT_BUS,
  .DATA_OUT_BUS_OE, .EMPTY_OR_OUT_READY, .FULL_OR_IN_READY, .HALF_FULL_N, .ALMOST_EMPTY_N,
  .ALMOST_FULL_N);
`default_nettype wire

// [fifo_pkg.sv]
// Shared types and constants of the dual clock flagged buffer.
// Assumes one system clock samples both link clocks and every pin.
package fifo_pkg;

  localparam int WORD_W = 18;
  localparam int PTR_W = 17;
  localparam int OFF_W = 16;
  localparam int DEPTH_SMALL = 32768;
  localparam int DEPTH_LARGE = 65536;

  // Offsets loaded at master reset, chosen by the load select pin
  localparam logic [15:0] OFFSET_DEFAULT_PARALLEL = 16'h007F;
  localparam logic [15:0] OFFSET_DEFAULT_SERIAL = 16'h03FF;

  // Serial offset bit positions: empty offset first, then full offset
  localparam logic [4:0] SERIAL_EMPTY_LSB = 5'h00;
  localparam logic [4:0] SERIAL_FULL_LSB = 5'h10;

  // Read clock rising edges before the first word falls through
  localparam logic [1:0] FALL_THROUGH_EDGES = 2'h2;
  // Read clock rising edges the retransmit masks the empty side
  localparam logic [1:0] RETRANSMIT_HOLD_EDGES = 2'h2;

  typedef struct packed {
    logic write_clock;
    logic read_clock;
    logic write_enable_n;
    logic read_enable_n;
    logic offset_load_select_n;
    logic serial_load_enable_n;
    logic mode_select_serial_in;
    logic master_reset_n;
    logic partial_reset_n;
    logic retransmit_n;
    logic output_enable_n;
    logic [WORD_W-1:0] data;
  } pins_t;

  typedef struct packed {
    logic empty_or_out_ready;
    logic full_or_in_ready;
    logic half_full_n;
    logic almost_empty_n;
    logic almost_full_n;
    logic data_out_enable;
  } flags_t;

  typedef struct packed {
    pins_t s1;
    pins_t s2;
    pins_t s3;
    logic fall_through_timing;
    logic serial_mode;
    logic [OFF_W-1:0] empty_offset;
    logic [OFF_W-1:0] full_offset;
    logic [PTR_W-1:0] wptr;
    logic [PTR_W-1:0] wptr_d1;
    logic [PTR_W-1:0] wptr_d2;
    logic [PTR_W-1:0] rptr;
    logic [WORD_W-1:0] q;
    logic out_valid;
    logic [4:0] serial_bit;
    logic write_offset_index;
    logic read_offset_index;
    logic [1:0] fall_count;
    logic [1:0] retransmit_hold;
    flags_t flags;
  } state_t;

  localparam state_t STATE_RESET = '0;

endpackage

// [fifo_store.sv]
// Word store of the buffer: one write port, one read port, registered read data.
// Assumes the caller keeps the read address steady while it waits for data.
`timescale 1ns/10ps
`default_nettype none
module fifo_store #(
  parameter int DEPTH = fifo_pkg::DEPTH_SMALL,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [fifo_pkg::WORD_W-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [fifo_pkg::WORD_W-1:0] rd_data
);

  logic [fifo_pkg::WORD_W-1:0] mem [DEPTH];

  // No reset: contents are undefined until written, as in any large array
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule
`default_nettype wire

// [link_partner.sv]
// Writer and reader link clocks of the buffer's far side.
// Assumes a 250 MHz clk; each link clock has an 80 ns period.
`timescale 1ns/10ps
`default_nettype none
module link_partner (
  input wire logic clk,
  output logic write_clock,
  output logic read_clock
);
  logic [4:0] wc = 5'h00;
  logic [4:0] rc = 5'h09;
  // Offset phases leave a quiet gap after every rising edge
  always @(posedge clk) begin
    wc <= (wc == 5'h13) ? 5'h00 : wc + 5'h01;
    rc <= (rc == 5'h13) ? 5'h00 : rc + 5'h01;
  end
  assign write_clock = wc > 5'h09;
  assign read_clock = rc > 5'h09;
endmodule
`default_nettype wire

// [testbench.sv]
// Self-checking bench of the dual clock buffer.
// Assumes link_partner makes both link clocks from CLK.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic CLK = 1'b0;
  logic RST_B = 1'b0;
  logic wclk, rclk, wen_n, ren_n, lsel_n, ser_en_n, mode_bit;
  logic mreset_n, preset_n, rewind_n, oe_n;
  logic doe, empty_rdy, room_rdy, half_n, ae_n, af_n;
  logic [17:0] din, dout;
  logic [17:0] wd [3] = '{18'h2A5C3, 18'h15A3C, 18'h3FFFF};
  logic [31:0] sv = 32'h00040003;
  int errors = 0;
  int checks_done = 0;
  link_partner u_link (.clk(CLK), .write_clock(wclk), .read_clock(rclk));
  dual_clock_flagged_fifo u_dut (.CLK(CLK), .RST_B(RST_B), .WRITE_CLOCK(wclk),
    .READ_CLOCK(rclk), .WRITE_ENABLE_N(wen_n), .READ_ENABLE_N(ren_n), .DATA_IN_BUS(din),
    .OFFSET_LOAD_SELECT_N(lsel_n), .SERIAL_LOAD_ENABLE_N(ser_en_n),
    .MODE_SELECT_SERIAL_IN(mode_bit), .MASTER_RESET_N(mreset_n), .PARTIAL_RESET_N(preset_n),
    .RETRANSMIT_N(rewind_n), .OUTPUT_ENABLE_N(oe_n), .DATA_OUT_BUS(dout),
    .DATA_OUT_BUS_OE(doe), .EMPTY_OR_OUT_READY(empty_rdy), .FULL_OR_IN_READY(room_rdy),
    .HALF_FULL_N(half_n), .ALMOST_EMPTY_N(ae_n), .ALMOST_FULL_N(af_n));
  task automatic check(input string name, input logic [17:0] seen, input logic [17:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic results;
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
  endtask
  // Controls move in the link clock's low phase, far from its rising edge
  task automatic wop(input logic w, input logic l, input logic s, input logic b,
    input logic [17:0] d);
    @(negedge wclk);
    @(posedge CLK);
    {wen_n, lsel_n, ser_en_n, mode_bit, din} <= {w, l, s, b, d};
    @(negedge wclk);
    @(posedge CLK);
    {wen_n, lsel_n, ser_en_n, mode_bit, din} <= {4'hE, ~d};
    #1;
  endtask
  task automatic rop(input logic r, input logic l, input logic t);
    @(negedge rclk);
    @(posedge CLK);
    {ren_n, lsel_n, rewind_n} <= {r, l, t};
    @(negedge rclk);
    @(posedge CLK);
    {ren_n, lsel_n, rewind_n} <= 3'h7;
    #1;
  endtask
  task automatic mreset(input logic m, input logic l);
    @(posedge CLK);
    {mreset_n, mode_bit, lsel_n} <= {1'b0, m, l};
    cyc(30);
    mreset_n <= 1'b1;
    cyc(4);
    {mode_bit, lsel_n} <= 2'h1;
    cyc(10);
    #1;
  endtask
  task automatic t_std;
    mreset(1'b0, 1'b0);
    check("empty flag", empty_rdy, 18'h0);
    check("full flag", room_rdy, 18'h1);
    check("almost empty", ae_n, 18'h0);
    check("almost full", af_n, 18'h1);
    check("half full", half_n, 18'h1);
    for (int i = 0; i < 3; i++)
      wop(1'b0, 1'b1, 1'b1, 1'b0, wd[i]);
    check("held output", dout, 18'h0);
    check("empty flag", empty_rdy, 18'h1);
    for (int i = 0; i < 4; i++) begin
      rop(1'b0, 1'b1, 1'b1);
      check("read word", dout, wd[i > 2 ? 2 : i]);
    end
    check("empty flag", empty_rdy, 18'h0);
  endtask
  // Full offset of 32767 puts the almost-full limit at one stored word
  task automatic t_par;
    wop(1'b0, 1'b0, 1'b1, 1'b0, 18'h00002);
    wop(1'b0, 1'b0, 1'b1, 1'b0, 18'h07FFF);
    rop(1'b0, 1'b0, 1'b1);
    check("empty offset", dout, 18'h00002);
    rop(1'b0, 1'b0, 1'b1);
    check("full offset", dout, 18'h07FFF);
    wop(1'b0, 1'b1, 1'b1, 1'b0, wd[0]);
    check("almost empty", ae_n, 18'h0);
    check("almost full", af_n, 18'h1);
    wop(1'b0, 1'b1, 1'b1, 1'b0, wd[1]);
    check("almost empty", ae_n, 18'h1);
    check("almost full", af_n, 18'h0);
  endtask
  task automatic t_rt;
    rop(1'b1, 1'b1, 1'b0);
    check("empty flag", empty_rdy, 18'h0);
    rop(1'b1, 1'b1, 1'b1);
    rop(1'b0, 1'b1, 1'b1);
    check("reread word", dout, wd[0]);
    check("almost empty", ae_n, 18'h1);
  endtask
  task automatic t_prs;
    @(posedge CLK);
    preset_n <= 1'b0;
    cyc(30);
    preset_n <= 1'b1;
    cyc(10);
    #1;
    check("cleared output", dout, 18'h0);
    check("empty flag", empty_rdy, 18'h0);
    rop(1'b0, 1'b0, 1'b1);
    check("kept offset", dout, 18'h00002);
  endtask
  task automatic t_oe;
    check("output enable", doe, 18'h1);
    @(posedge CLK);
    oe_n <= 1'b1;
    cyc(8);
    #1;
    check("output enable", doe, 18'h0);
    @(posedge CLK);
    oe_n <= 1'b0;
  endtask
  task automatic t_flow;
    mreset(1'b1, 1'b1);
    check("ready flag", empty_rdy, 18'h1);
    check("room flag", room_rdy, 18'h0);
    for (int i = 0; i < 2; i++) begin
      rop(1'b0, 1'b0, 1'b1);
      check("default offset", dout, 18'h003FF);
    end
    for (int i = 0; i < 32; i++)
      wop(1'b1, 1'b0, 1'b0, sv[i], 18'h0);
    for (int i = 0; i < 2; i++) begin
      rop(1'b0, 1'b0, 1'b1);
      check("serial offset", dout, {2'h0, i ? sv[31:16] : sv[15:0]});
    end
    wop(1'b0, 1'b1, 1'b1, 1'b0, wd[0]);
    cyc(80);
    check("fall through", dout, wd[0]);
    check("ready flag", empty_rdy, 18'h0);
    wop(1'b0, 1'b1, 1'b1, 1'b0, wd[1]);
    cyc(80);
    check("held word", dout, wd[0]);
    check("almost empty", ae_n, 18'h0);
    rop(1'b0, 1'b1, 1'b1);
    check("next word", dout, wd[1]);
    rop(1'b0, 1'b1, 1'b1);
    check("ready flag", empty_rdy, 18'h1);
  endtask
  initial begin
    forever #2 CLK = ~CLK;
  end
  initial begin
    cyc(20000);
    errors++;
    results;
  end
  initial begin
    {wen_n, ren_n, lsel_n, ser_en_n, rewind_n, mreset_n, preset_n} <= 7'h7F;
    {mode_bit, oe_n, din} <= '0;
    cyc(20);
    RST_B <= 1'b1;
    cyc(10);
    t_std;
    t_par;
    t_rt;
    t_prs;
    t_oe;
    t_flow;
    results;
  end
endmodule
`default_nettype wire
